// ===== hdl/pcar_router.v
// host configuration access router: address register, data window, routing, internal regs
// Notes on behaviour
// R1 - byte word dword access; address register dword only
// R2 - multi-byte fields stored little-endian
// R3 - read-only registers ignore writes
// R4 - write one clears, write zero keeps
// R5 - write-once bits take one write
// R6 - lockable bits freeze once lock set
// R7 - reserved locations read arbitrary (zero here)
// R8 - software preserves reserved bits
// R9 - reset loads default register values
// R10 - only mechanism one supported
// R11 - host writes address register first
// R12 - cycles only when enable bit set
// R13 - data window access becomes configuration cycle
// R14 - bus field decoded, zero is bus zero
// R15 - devices zero and one served internally
// R16 - bus zero devices 2-31 go hub
// R17 - outside secondary..subordinate goes hub
// R18 - secondary bus gives AGP type 0
// R19 - above secondary to subordinate gives type 1
// R20 - primary bus number fixed zero
// R21 - eight functions, 64 dword registers addressable
// R22 - internal devices ignore nonzero function
// R23 - type 0 one idsel line, dev<=20
// R24 - narrow address register access passes through
// R25 - function and register fields on address lines
// R26 - window inert while enable clear
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "pcar_regs.vh"
module pcar_router
(
   input wire CLK_SYS,
   input wire RST_N,
   input wire [15:0] IO_ADDR,
   input wire [3:0] IO_BE,
   input wire [31:0] IO_WDATA,
   input wire IO_WR,
   input wire IO_RD,
   output reg [31:0] IO_RDATA,
   output reg IO_HIT,
   output reg PASS_IO,
   output reg CFG_REQ,
   output reg CFG_WR,
   output reg [2:0] CFG_ROUTE,
   output reg [31:0] CFG_ADDR,
   output reg [3:0] CFG_BE,
   output reg [31:0] CFG_WDATA,
   output reg [7:0] HW_W1C_SET,
   output reg [7:0] SEC_BUS,
   output reg [7:0] SUB_BUS
);
   reg [31:0] ca_r;
   reg [7:0] sec_r;
   reg [7:0] sub_r;
   reg [31:0] w1c_r;
   reg [15:0] wo_r;
   reg wo_done_r;
   reg [15:0] lck_r;
   reg lbit_r;
   reg [2:0] route;
   reg [31:0] caddr;
   reg [31:0] rd_nxt;
   wire [7:0] bus = ca_r[`PCAR_BUS_HI:`PCAR_BUS_LO];
   wire [4:0] dev = ca_r[`PCAR_DEV_HI:`PCAR_DEV_LO];
   wire [2:0] fn = ca_r[`PCAR_FN_HI:`PCAR_FN_LO];
   wire [5:0] rg = ca_r[`PCAR_RG_HI:`PCAR_RG_LO];
   wire [7:0] roff = {rg, 2'b00};
   wire en = ca_r[`PCAR_CA_EN];
   wire hit_ca = (IO_ADDR == `PCAR_IO_ADDR);
   wire full = (IO_BE == 4'hf);
   wire hit_cd = (IO_ADDR == `PCAR_IO_DATA);
   wire win = hit_cd & en; // R12 R26
   wire int_wr = win & IO_WR & (route == `PCAR_RT_INT);
   wire int_rd = win & IO_RD & (route == `PCAR_RT_INT);
   wire [31:0] bm = {{8{IO_BE[3]}}, {8{IO_BE[2]}}, {8{IO_BE[1]}}, {8{IO_BE[0]}}};
   // hardware status event: type 0 cycle issued with no device select line
   wire [7:0] hw_set = {7'h00, CFG_REQ & (CFG_ROUTE == `PCAR_RT_AGP0) & (CFG_ADDR[31:11] == 21'h000000)};

   ////////////////////////////////////////////////////////////////
   // merge enabled byte lanes, lane 0 is least significant
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m); // R2
      end
   endfunction

   wire [31:0] wo_m = merge({16'h0000, wo_r}, IO_WDATA, bm);
   wire [31:0] lck_m = merge({16'h0000, lck_r}, IO_WDATA, bm);

   ////////////////////////////////////////////////////////////////
   // routing decode
   always @*
   begin
      route = `PCAR_RT_NONE;
      caddr = 32'h0000_0000;
      if (bus == 8'h00) // R14
      begin
         if (dev == 5'h00 || dev == 5'h01)
         begin
            if (fn == 3'h0) // R22
               route = `PCAR_RT_INT; // R15
         end
         else
            route = `PCAR_RT_HUB; // R16
         caddr = {16'h0000, dev, fn, rg, 2'b00};
      end
      else if (bus == sec_r)
      begin
         route = `PCAR_RT_AGP0; // R18
         if (dev <= `PCAR_IDSEL_MAX)
            caddr[`PCAR_IDSEL_BASE + dev] = 1'b1; // R23
         caddr[10:0] = {fn, rg, 2'b00}; // R25
      end
      else if (bus > sec_r && bus <= sub_r)
      begin
         route = `PCAR_RT_AGP1; // R19
         caddr = {8'h00, bus, dev, fn, rg, 2'b01};
      end
      else
      begin
         route = `PCAR_RT_HUB; // R17
         caddr = {8'h00, bus, dev, fn, rg, 2'b01};
      end
   end

   ////////////////////////////////////////////////////////////////
   // internal register read, reserved reads zero
   always @*
   begin
      rd_nxt = 32'h0000_0000;
      if (hit_ca & full)
         rd_nxt = ca_r;
      else if (int_rd)
      begin
         if (roff == `PCAR_CR_PRI && dev == 5'h01)
            rd_nxt = {8'h00, sub_r, sec_r, `PCAR_PRI_BUS}; // R20
         else if (roff == `PCAR_CR_W1C)
            rd_nxt = w1c_r;
         else if (roff == `PCAR_CR_WO)
            rd_nxt = {15'h0000, wo_done_r, wo_r};
         else if (roff == `PCAR_CR_LCK)
            rd_nxt = {16'h0000, lck_r};
         else if (roff == `PCAR_CR_LBIT)
            rd_nxt = {31'h0000_0000, lbit_r};
         else
            rd_nxt = 32'h0000_0000; // R7
      end
   end

   ////////////////////////////////////////////////////////////////
   // registers and cycle outputs
   always @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         ca_r <= `PCAR_CA_RST; // R9
         sec_r <= `PCAR_SEC_RST;
         sub_r <= `PCAR_SUB_RST;
         w1c_r <= 32'h0000_0000;
         wo_r <= 16'h0000;
         wo_done_r <= 1'b0;
         lck_r <= 16'h0000;
         lbit_r <= `PCAR_LOCK_RST;
         IO_RDATA <= 32'h0000_0000;
         IO_HIT <= 1'b0;
         PASS_IO <= 1'b0;
         CFG_REQ <= 1'b0;
         CFG_WR <= 1'b0;
         CFG_ROUTE <= `PCAR_RT_NONE;
         CFG_ADDR <= 32'h0000_0000;
         CFG_BE <= 4'h0;
         CFG_WDATA <= 32'h0000_0000;
         SEC_BUS <= `PCAR_SEC_RST;
         SUB_BUS <= `PCAR_SUB_RST;
      end
      else
      begin
         IO_RDATA <= rd_nxt;
         IO_HIT <= (IO_WR | IO_RD) & ((hit_ca & full) | win);
         PASS_IO <= (IO_WR | IO_RD) & hit_ca & ~full; // R24
         // R10 R11 R21: only dword address writes are taken
         if (IO_WR & hit_ca & full) // R1
            ca_r <= IO_WDATA & `PCAR_CA_WMASK;
         // R13: external routes emit one cycle per window access
         CFG_REQ <= (IO_WR | IO_RD) & win & (route != `PCAR_RT_INT) & (route != `PCAR_RT_NONE);
         CFG_WR <= IO_WR;
         CFG_ROUTE <= win ? route : `PCAR_RT_NONE;
         CFG_ADDR <= caddr; // R25
         CFG_BE <= IO_BE;
         CFG_WDATA <= IO_WDATA;
         // hardware events set, set wins over clear
         w1c_r <= (w1c_r & ~((int_wr && roff == `PCAR_CR_W1C) ? (IO_WDATA & bm) : 32'h0000_0000))
            | {24'h000000, hw_set}; // R4
         if (int_wr && dev == 5'h01 && roff == `PCAR_CR_PRI)
         begin
            sec_r <= IO_BE[1] ? IO_WDATA[15:8] : sec_r; // R3 R20
            sub_r <= IO_BE[2] ? IO_WDATA[23:16] : sub_r;
            SEC_BUS <= IO_BE[1] ? IO_WDATA[15:8] : sec_r;
            SUB_BUS <= IO_BE[2] ? IO_WDATA[23:16] : sub_r;
         end
         if (int_wr && roff == `PCAR_CR_WO && !wo_done_r)
         begin
            wo_r <= wo_m[15:0]; // R5
            wo_done_r <= 1'b1;
         end
         if (int_wr && roff == `PCAR_CR_LCK && !lbit_r)
            lck_r <= lck_m[15:0]; // R6
         if (int_wr && roff == `PCAR_CR_LBIT && IO_BE[0] && IO_WDATA[0])
            lbit_r <= 1'b1;
         HW_W1C_SET <= w1c_r[7:0];
      end
   end

endmodule

// ===== inc/pcar_regs.vh
// constants for the configuration access router
`ifndef PCAR_REGS_VH
`define PCAR_REGS_VH
`define PCAR_IO_ADDR 16'h0cf8
`define PCAR_IO_DATA 16'h0cfc
`define PCAR_CA_RST 32'h0000_0000
`define PCAR_CA_EN 31
`define PCAR_BUS_HI 23
`define PCAR_BUS_LO 16
`define PCAR_DEV_HI 15
`define PCAR_DEV_LO 11
`define PCAR_FN_HI 10
`define PCAR_FN_LO 8
`define PCAR_RG_HI 7
`define PCAR_RG_LO 2
`define PCAR_CA_WMASK 32'h80ff_fffc
`define PCAR_SEC_RST 8'h00
`define PCAR_SUB_RST 8'h00
`define PCAR_PRI_BUS 8'h00
`define PCAR_LOCK_RST 1'b0
`define PCAR_IDSEL_MAX 5'h14
`define PCAR_IDSEL_BASE 11
`define PCAR_RT_NONE 3'h0
`define PCAR_RT_INT 3'h1
`define PCAR_RT_HUB 3'h2
`define PCAR_RT_AGP0 3'h3
`define PCAR_RT_AGP1 3'h4
`define PCAR_CR_CAP 8'h00
`define PCAR_CR_SEC 8'h19
`define PCAR_CR_SUB 8'h1a
`define PCAR_CR_PRI 8'h18
`define PCAR_CR_W1C 8'h40
`define PCAR_CR_WO 8'h44
`define PCAR_CR_LCK 8'h48
`define PCAR_CR_LBIT 8'h4c
`endif

// ===== test/pcar_host.sv
// host processor model issuing I/O cycles
`timescale 1ns/10ps
module pcar_host
(
   input wire clk,
   output logic [15:0] addr,
   output logic [3:0] be,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd
);
   initial {addr, be, wdata, wr, rd} = '0;
   // one strobe cycle, returns once the answer has settled
   task xfer(input w, input [15:0] a, input [3:0] b, input [31:0] d);
   begin
      addr <= a;
      be <= b;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      #1;
   end
   endtask
endmodule

// ===== test/pcar_router_checker.sv
// port assertions for the router
`timescale 1ns/10ps
module pcar_router_checker
(
   input CLK_SYS,
   input RST_N,
   input [15:0] IO_ADDR,
   input [3:0] IO_BE,
   input [31:0] IO_WDATA,
   input IO_WR,
   input IO_RD,
   input IO_HIT,
   input PASS_IO,
   input CFG_REQ,
   input [2:0] CFG_ROUTE,
   input [31:0] CFG_ADDR,
   input [7:0] SEC_BUS,
   input [7:0] SUB_BUS
);
   reg [31:0] ca_r;
   wire acc = IO_WR | IO_RD;
   wire [7:0] bus = ca_r[23:16];
   wire [4:0] dev = ca_r[15:11];
   always @(posedge CLK_SYS)
      if (!RST_N)
         ca_r <= 32'h0;
      else if (IO_WR && IO_ADDR == 16'h0cf8 && IO_BE == 4'hf)
         ca_r <= IO_WDATA;
   ////////////////////
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   sequence s_win;
      acc && IO_ADDR == 16'h0cfc && ca_r[31];
   endsequence
   AST_DW: assert property (acc && IO_ADDR == 16'h0cf8 && IO_BE == 4'hf |=> IO_HIT && !PASS_IO)
      else $error("dword miss");
   AST_NARROW: assert property (acc && IO_ADDR == 16'h0cf8 && IO_BE != 4'hf |=> PASS_IO && !IO_HIT)
      else $error("narrow hit");
   AST_OFF: assert property (acc && IO_ADDR == 16'h0cfc && !ca_r[31] |=> !IO_HIT && !CFG_REQ)
      else $error("window live");
   AST_INT: assert property (s_win ##0 bus == 0 && dev < 2 |=> !CFG_REQ)
      else $error("internal sent");
   AST_HUB0: assert property (s_win ##0 bus == 0 && dev > 1 |=> CFG_REQ && CFG_ROUTE == 3'h2)
      else $error("bus0 route");
   AST_HUBN: assert property (s_win ##0 bus != 0 && (bus < SEC_BUS || bus > SUB_BUS) |=> CFG_ROUTE == 3'h2)
      else $error("hub route");
   AST_T0: assert property (s_win ##0 bus != 0 && bus == SEC_BUS |=> CFG_ROUTE == 3'h3 && $onehot0(CFG_ADDR[31:11]))
      else $error("type0");
   AST_T1: assert property (s_win ##0 bus > SEC_BUS && bus <= SUB_BUS |=> CFG_ROUTE == 3'h4)
      else $error("type1");
   AST_FLD: assert property (s_win ##0 bus != 0 |=> CFG_ADDR[10:2] == $past(ca_r[10:2]))
      else $error("fields");
endmodule
bind pcar_router pcar_router_checker u_chk (.*);

// ===== test/pcar_router_tb.sv
// self-checking bench for the router
`timescale 1ns/10ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module pcar_router_tb;
   logic clk_sys = 0;
   logic rst_n = 0;
   wire [15:0] io_addr;
   wire [3:0] io_be, cfg_be;
   wire [31:0] io_wdata, io_rdata, cfg_addr, cfg_wdata;
   wire io_wr, io_rd, io_hit, pass_io, cfg_req, cfg_wr;
   wire [2:0] cfg_route;
   wire [7:0] w1c, sec_bus, sub_bus;
   int errors = 0, checks_done = 0, bus, dev, fn, rg, w;
   logic [31:0] d, ea;
   logic [2:0] rt;
   initial forever #50 clk_sys = ~clk_sys;
   pcar_host host (.clk(clk_sys), .addr(io_addr), .be(io_be), .wdata(io_wdata), .wr(io_wr), .rd(io_rd));
   pcar_router DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_BE(io_be), .IO_WDATA(io_wdata),
      .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata), .IO_HIT(io_hit), .PASS_IO(pass_io), .CFG_REQ(cfg_req),
      .CFG_WR(cfg_wr), .CFG_ROUTE(cfg_route), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
      .HW_W1C_SET(w1c), .SEC_BUS(sec_bus), .SUB_BUS(sub_bus));
   ////////////////////
   task cfg(input w, input [31:0] a, input [3:0] b, input [31:0] v);
   begin
      host.xfer(1, 16'h0cf8, 4'hf, a);
      host.xfer(w, 16'h0cfc, b, v);
   end
   endtask
   // expected route and address, secondary 5, subordinate 9
   task calc;
   begin
      rt = bus == 0 ? (dev > 1 ? 3'h2 : fn ? 3'h0 : 3'h1) : bus == 5 ? 3'h3 : (bus > 5 && bus <= 9) ? 3'h4 : 3'h2;
      ea = rt == 3'h3 ? (dev < 21 ? 32'h800 << dev : 0) | fn << 8 | rg << 2 :
         bus ? {bus[7:0], dev[4:0], fn[2:0], rg[5:0], 2'b01} : {dev[4:0], fn[2:0], rg[5:0], 2'b00};
   end
   endtask
   task final_report;
   begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   ////////////////////
   initial
   begin
      d = $urandom(32'h7617e342);
      repeat (5) @(posedge clk_sys);
      rst_n <= 1;
      @(posedge clk_sys);
      host.xfer(0, 16'h0cf8, 4'hf, 0);
      `CK({io_rdata, sec_bus, sub_bus, w1c}, 56'h0)
      host.xfer(1, 16'h0cf8, 4'h1, 32'h8000_0000);
      `CK({pass_io, io_hit}, 2'b10)
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK({io_hit, cfg_req}, 2'b00)
      cfg(1, 32'h8000_0818, 4'hf, 32'h0009_05ff);
      `CK({cfg_req, sec_bus, sub_bus}, 17'h00509)
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK(io_rdata, 32'h0009_0500)
      cfg(1, 32'h8000_0044, 4'h3, 32'h1234);
      host.xfer(1, 16'h0cfc, 4'h3, 32'h5678);
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK(io_rdata, 32'h0001_1234)
      cfg(1, 32'h8000_0048, 4'hf, 32'haaaa);
      cfg(1, 32'h8000_004c, 4'h1, 1);
      cfg(1, 32'h8000_0048, 4'hf, 32'h5555);
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK(io_rdata[15:0], 16'haaaa)
      repeat (60)
      begin
         bus = $urandom_range(1) ? 0 : $urandom_range(12, 1);
         dev = $urandom_range(1) ? $urandom_range(2) : $urandom_range(31);
         fn = $urandom_range(1) ? 0 : $urandom_range(7);
         rg = $urandom_range(63);
         calc;
         w = rt > 1 ? $urandom_range(1) : 0;
         d = $urandom;
         cfg(w, {8'h80, bus[7:0], dev[4:0], fn[2:0], rg[5:0], 2'b00}, 4'hf, d);
         `CK({cfg_req, cfg_route}, {rt > 1, rt})
         if (rt > 1)
            `CK({cfg_addr, cfg_wr}, {ea, w[0]})
         if (rt > 1)
            `CK({cfg_be, cfg_wdata}, {4'hf, d})
         if (rt == 0)
            `CK(io_rdata, 32'h0)
      end
      cfg(0, 32'h8005_c800, 4'hf, 0);
      cfg(1, 32'h8000_0040, 4'h1, 0);
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK({io_rdata[0], w1c[0]}, 2'b11)
      host.xfer(1, 16'h0cfc, 4'h1, 1);
      host.xfer(0, 16'h0cfc, 4'hf, 0);
      `CK({io_rdata[0], w1c[0]}, 2'b00)
      final_report;
   end
endmodule
